// ==== common/lsb_event_pkg.sv ====
// constants shared by the load/store event monitor and its helpers
// assumes one core clock and an apb3 register port
package lsb_event_pkg;
  localparam logic [7:0] EVC_LOAD_BLOCK  = 8'h03;
  localparam logic [7:0] EVC_STORE_BLOCK = 8'h04;
  localparam logic [7:0] UM_OVERLAP      = 8'h08;
  localparam logic [7:0] UM_UNTIL_RETIRE = 8'h10;
  localparam logic [7:0] UM_L1D          = 8'h20;
  localparam logic [7:0] UM_DRAIN        = 8'h01;
  localparam logic [7:0] UM_ORDER        = 8'h02;

  localparam int EV_N   = 5;
  localparam int EV_OVL = 0;
  localparam int EV_RET = 1;
  localparam int EV_L1D = 2;
  localparam int EV_DRN = 3;
  localparam int EV_ORD = 4;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SELECT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0C;
  localparam logic [7:0] OFS_STATE  = 8'h10;

  localparam int CTRL_EN_BIT     = 0;
  localparam int SEL_CODE_LSB    = 0;
  localparam int SEL_UMASK_LSB   = 8;
  localparam int STATE_HOLD_BIT  = 0;
  localparam int STATE_DRAIN_BIT = 1;
  localparam int STATE_ORDER_BIT = 2;
  localparam int STATE_MISS_LSB  = 8;

  localparam logic [7:0] RST_CODE  = 8'h00;
  localparam logic [7:0] RST_UMASK = 8'h00;

  // load/store size codes: bytes = 1 << code
  localparam logic [2:0] SZ_1  = 3'h0;
  localparam logic [2:0] SZ_2  = 3'h1;
  localparam logic [2:0] SZ_4  = 3'h2;
  localparam logic [2:0] SZ_8  = 3'h3;
  localparam logic [2:0] SZ_16 = 3'h4;

  localparam int PAGE_OFS_W = 12;
  localparam int LINE_OFS_W = 6;
  localparam logic [6:0] LINE_BYTES = 7'h40;
  localparam logic [4:0] QWORD_BYTES = 5'h08;

  typedef enum logic [1:0] {ORD_IDLE, ORD_WAIT_OBS, ORD_WAIT_SNOOP} ord_state_t;

  function automatic logic [4:0] size_bytes(input logic [2:0] sz);
    size_bytes = 5'h01 << sz;
  endfunction

  function automatic logic misaligned(input logic [3:0] a, input logic [2:0] sz);
    logic [4:0] m;
    m = size_bytes(sz) - 5'h01;
    misaligned = |(a & m[3:0]);
  endfunction
endpackage

// ==== hw/overlap_classifier.sv ====
// combinational check of one load against the youngest older store
// assumes both addresses are full byte addresses of the same width
`timescale 1ns/1ps
module overlap_classifier import lsb_event_pkg::*; #(
  parameter int ADDR_W = 32
) (
  input  wire logic [ADDR_W-1:0] load_addr,
  input  wire logic [2:0]        load_sz,
  input  wire logic              store_valid,
  input  wire logic [ADDR_W-1:0] store_addr,
  input  wire logic [2:0]        store_sz,
  output logic                   straddle,
  output logic                   alias_4k,
  output logic                   block
);
  logic [ADDR_W:0] l_end;
  logic [ADDR_W:0] s_end;
  logic            ovl;
  logic            covered;
  logic            s_alg;
  logic [4:0]      l_qw;

  assign l_end   = {1'b0, load_addr} + {{(ADDR_W-4){1'b0}}, size_bytes(load_sz)};
  assign s_end   = {1'b0, store_addr} + {{(ADDR_W-4){1'b0}}, size_bytes(store_sz)};
  assign ovl     = store_valid && (l_end > {1'b0, store_addr}) && (s_end > {1'b0, load_addr});
  assign covered = (store_addr <= load_addr) && (l_end <= s_end);
  assign s_alg   = !misaligned(store_addr[3:0], store_sz);
  assign l_qw    = {2'b00, load_addr[2:0]} + size_bytes(load_sz);
  assign straddle = (l_qw > QWORD_BYTES) && (load_sz != SZ_16);
  assign alias_4k = store_valid && (load_addr[PAGE_OFS_W-1:0] == store_addr[PAGE_OFS_W-1:0])
                 && (load_addr[ADDR_W-1:PAGE_OFS_W] != store_addr[ADDR_W-1:PAGE_OFS_W]);

  always_comb begin
    block = 1'b0;
    if (ovl && !covered) block = 1'b1;
    if (ovl && s_alg && (load_sz <= SZ_2) && (load_addr != store_addr)) block = 1'b1;
    if (ovl && s_alg && (load_sz == SZ_4 || load_sz == SZ_8)
        && misaligned(load_addr[3:0], load_sz)) block = 1'b1;
    if (ovl && !s_alg && (load_addr != store_addr)) block = 1'b1;
    if (straddle || alias_4k) block = 1'b1;
  end

  initial begin
    if (ADDR_W <= PAGE_OFS_W) $error("ADDR_W must exceed the page offset width");
  end
endmodule

// ==== hw/store_order_tracker.sv ====
// store buffer drain and store ordering stall tracking
// assumes the pipeline flags arrive on pclk, already registered
`timescale 1ns/1ps
module store_order_tracker import lsb_event_pkg::*; (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic drain_cause,
  input  wire logic sb_empty,
  input  wire logic store_wait,
  input  wire logic st_l1_miss,
  input  wire logic st_hit_shared,
  input  wire logic bus_read,
  input  wire logic snoop_resp,
  input  wire logic line_observed,
  output logic      drain_cycle,
  output logic      order_stall
);
  typedef struct packed {
    logic       drain;
    ord_state_t ord;
    logic       stall;
  } trk_t;
  trk_t s_r;
  trk_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (drain_cause) s_nxt.drain = 1'b1;
    else if (sb_empty) s_nxt.drain = 1'b0;
    case (s_r.ord)
      ORD_IDLE: begin
        if (store_wait && (st_l1_miss || st_hit_shared)) begin
          s_nxt.ord = bus_read ? ORD_WAIT_SNOOP : ORD_WAIT_OBS;
        end
      end
      ORD_WAIT_OBS: begin
        if (line_observed) s_nxt.ord = ORD_IDLE;
      end
      ORD_WAIT_SNOOP: begin
        if (snoop_resp) s_nxt.ord = ORD_IDLE;
      end
      default: s_nxt.ord = ORD_IDLE;
    endcase
    s_nxt.stall = (s_nxt.ord != ORD_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_r <= '{drain: 1'b0, ord: ORD_IDLE, stall: 1'b0};
    else if (ce) s_r <= s_nxt;
  end

  assign drain_cycle = s_r.drain;
  assign order_stall = s_r.stall;

  drain_start_a:
  assert property (@(posedge pclk) disable iff (!presetn) ce && drain_cause |=> drain_cycle)
    else $error("drain cause did not start drain cycles");
  snoop_end_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && s_r.ord == ORD_WAIT_SNOOP && snoop_resp |=> !order_stall)
    else $error("ordering stall outlived the snoop response");
  order_start_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && s_r.ord == ORD_IDLE && store_wait && (st_l1_miss || st_hit_shared) |=> order_stall)
    else $error("missing or shared store did not stall");
endmodule

// ==== hw/lsb_event_monitor.sv ====
// load/store block event monitor with apb3 registers and interrupt
// assumes pipeline inputs are on pclk; pulse feeds an external counter
//
// How it works
// - a load partly covered by an older store is blocked and counted.
// - loads from size-aligned older stores are candidates by size and alignment.
// - a 1/2-byte load not aligned to an aligned store is blocked.
// - a misaligned 4/8-byte load from an aligned store is blocked.
// - a load from a misaligned store not at its first byte is blocked.
// - a load straddling an 8-byte boundary is blocked, 16-byte loads excepted.
// - same 4K page offset in different pages blocks the load.
// - a blocked load stays stalled until the blocking store commits.
// - code 03H mask 10H counts loads held until retirement.
// - held-until-retire covers uncacheable, line-split and other deferred loads.
// - code 03H mask 20H counts loads blocked by full miss tracking.
// - line splits, partial reads and locked-load periods also count as cache blocks.
// - code 04H mask 01H counts every store buffer drain cycle.
// - drains come from serializing, exchange, interrupt ack and flush.
// - code 04H mask 02H counts cycles a store waits on ordering.
// - the ordering stall arises on store miss or shared hit.
// - a stall needing a bus read ends at its snoop response.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module lsb_event_monitor import lsb_event_pkg::*; #(
  parameter int ADDR_W   = 32,
  parameter int MAX_MISS = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              load_valid,
  input  wire logic [ADDR_W-1:0] load_addr,
  input  wire logic [2:0]        load_sz,
  input  wire logic              load_uncacheable,
  input  wire logic              load_io,
  input  wire logic              load_deferred,
  input  wire logic              load_l1_miss,
  input  wire logic              locked_load_busy,
  input  wire logic              store_valid,
  input  wire logic [ADDR_W-1:0] store_addr,
  input  wire logic [2:0]        store_sz,
  input  wire logic              store_committed,
  input  wire logic              miss_alloc,
  input  wire logic              miss_done,
  input  wire logic              serialize_op,
  input  wire logic              atomic_exchange_op,
  input  wire logic              int_ack,
  input  wire logic              cache_flush,
  input  wire logic              sb_empty,
  input  wire logic              store_wait,
  input  wire logic              st_l1_miss,
  input  wire logic              st_hit_shared,
  input  wire logic              bus_read,
  input  wire logic              snoop_resp,
  input  wire logic              line_observed,
  output logic                   event_pulse,
  output logic                   load_stall,
  output logic                   store_order_stall,
  output logic                   irq
);
  localparam int MW = $clog2(MAX_MISS + 1);
  localparam logic [MW-1:0] MISS_MAX = MW'(MAX_MISS);

  typedef struct packed {
    logic              en;
    logic [7:0]        code;
    logic [7:0]        umask;
    logic [EV_N-1:0]   status;
    logic [EV_N-1:0]   mask;
    logic              hold;
    logic [MW-1:0]     misses;
    logic              pulse;
    logic              irq;
    logic [31:0]       rdata;
    logic              ready;
    logic              err;
  } mon_t;

  mon_t s_r;
  mon_t s_nxt;

  // one-hot of the event that a code/mask pair picks; unknown pairs pick none
  function automatic logic [EV_N-1:0] sel_decode(input logic [7:0] c, input logic [7:0] u);
    logic [EV_N-1:0] v;
    v = '0;
    if (c == EVC_LOAD_BLOCK && u == UM_OVERLAP) v[EV_OVL] = 1'b1;
    if (c == EVC_LOAD_BLOCK && u == UM_UNTIL_RETIRE) v[EV_RET] = 1'b1;
    if (c == EVC_LOAD_BLOCK && u == UM_L1D) v[EV_L1D] = 1'b1;
    if (c == EVC_STORE_BLOCK && u == UM_DRAIN) v[EV_DRN] = 1'b1;
    if (c == EVC_STORE_BLOCK && u == UM_ORDER) v[EV_ORD] = 1'b1;
    sel_decode = v;
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == OFS_CTRL) || (a == OFS_SELECT) || (a == OFS_STATUS)
           || (a == OFS_MASK) || (a == OFS_STATE);
  endfunction

  logic            straddle;
  logic            alias_4k;
  logic            ovl_block;
  logic            drain_cycle;
  logic            order_stall;
  logic            line_split;
  logic [6:0]      l_end_ofs;
  logic            miss_full;
  logic [EV_N-1:0] ev;
  logic [EV_N-1:0] sel;
  logic            setup;
  logic            acc_wr;

  overlap_classifier #(
    .ADDR_W (ADDR_W)
  ) u_cls (
    .load_addr   (load_addr),
    .load_sz     (load_sz),
    .store_valid (store_valid),
    .store_addr  (store_addr),
    .store_sz    (store_sz),
    .straddle    (straddle),
    .alias_4k    (alias_4k),
    .block       (ovl_block)
  );

  store_order_tracker u_trk (
    .pclk          (pclk),
    .presetn       (presetn),
    .ce            (ce),
    .drain_cause   (serialize_op | atomic_exchange_op | int_ack | cache_flush),
    .sb_empty      (sb_empty),
    .store_wait    (store_wait),
    .st_l1_miss    (st_l1_miss),
    .st_hit_shared (st_hit_shared),
    .bus_read      (bus_read),
    .snoop_resp    (snoop_resp),
    .line_observed (line_observed),
    .drain_cycle   (drain_cycle),
    .order_stall   (order_stall)
  );

  assign l_end_ofs  = {1'b0, load_addr[LINE_OFS_W-1:0]} + {2'b00, size_bytes(load_sz)};
  assign line_split = l_end_ofs > LINE_BYTES;
  assign miss_full  = s_r.misses >= MISS_MAX;
  assign sel        = sel_decode(s_r.code, s_r.umask);
  // fixed zero wait states: the answer is registered, so it never arrives with setup
  assign setup      = psel && !penable;
  assign acc_wr     = psel && penable && s_r.ready && pwrite;

  // a held load is not recounted while it waits for its store
  always_comb begin
    ev = '0;
    ev[EV_OVL] = load_valid && ovl_block && !s_r.hold;
    ev[EV_RET] = load_valid && (load_uncacheable || line_split || load_deferred);
    ev[EV_L1D] = load_valid && ((load_l1_miss && miss_full)
                 || line_split || load_uncacheable || load_io || locked_load_busy);
    ev[EV_DRN] = drain_cycle;
    ev[EV_ORD] = order_stall;
  end

  always_comb begin
    s_nxt = s_r;
    // outstanding misses: demand and both prefetch kinds arrive on miss_alloc
    if (miss_alloc && !miss_done && !miss_full) s_nxt.misses = s_r.misses + MW'(1);
    else if (miss_done && !miss_alloc && s_r.misses != '0) s_nxt.misses = s_r.misses - MW'(1);
    if (ev[EV_OVL]) s_nxt.hold = 1'b1;
    else if (store_committed) s_nxt.hold = 1'b0;
    s_nxt.pulse = s_r.en && |(sel & ev);
    s_nxt.ready = 1'b0;
    s_nxt.err   = 1'b0;
    if (setup) begin
      s_nxt.ready = 1'b1;
      s_nxt.err   = !reg_hit(paddr);
      s_nxt.rdata = '0;
      case (paddr)
        OFS_CTRL:   s_nxt.rdata[CTRL_EN_BIT] = s_r.en;
        OFS_SELECT: begin
          s_nxt.rdata[SEL_CODE_LSB +: 8]  = s_r.code;
          s_nxt.rdata[SEL_UMASK_LSB +: 8] = s_r.umask;
        end
        OFS_STATUS: s_nxt.rdata[EV_N-1:0] = s_r.status;
        OFS_MASK:   s_nxt.rdata[EV_N-1:0] = s_r.mask;
        OFS_STATE: begin
          s_nxt.rdata[STATE_HOLD_BIT]  = s_r.hold;
          s_nxt.rdata[STATE_DRAIN_BIT] = drain_cycle;
          s_nxt.rdata[STATE_ORDER_BIT] = order_stall;
          s_nxt.rdata[STATE_MISS_LSB +: MW] = s_r.misses;
        end
        default: s_nxt.rdata = '0;
      endcase
    end
    s_nxt.status = s_r.status;
    if (acc_wr) begin
      case (paddr)
        OFS_CTRL:   s_nxt.en = pwdata[CTRL_EN_BIT];
        OFS_SELECT: begin
          s_nxt.code  = pwdata[SEL_CODE_LSB +: 8];
          s_nxt.umask = pwdata[SEL_UMASK_LSB +: 8];
        end
        OFS_STATUS: s_nxt.status = s_r.status & ~pwdata[EV_N-1:0];
        OFS_MASK:   s_nxt.mask = pwdata[EV_N-1:0];
        default:    s_nxt.en = s_r.en;
      endcase
    end
    // set after clear so a same-cycle event survives the write-one-to-clear
    s_nxt.status = s_nxt.status | ev;
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{en:     1'b0,
               code:   RST_CODE,
               umask:  RST_UMASK,
               status: '0,
               mask:   '0,
               hold:   1'b0,
               misses: '0,
               pulse:  1'b0,
               irq:    1'b0,
               rdata:  '0,
               ready:  1'b0,
               err:    1'b0};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign prdata            = s_r.rdata;
  assign pready            = s_r.ready;
  assign pslverr           = s_r.err;
  assign event_pulse       = s_r.pulse;
  assign load_stall        = s_r.hold;
  assign store_order_stall = order_stall;
  assign irq               = s_r.irq;

  // the state register gives the miss count eight bits, hence the upper limit
  initial begin
    if (MAX_MISS < 1 || MAX_MISS > 255) $error("MAX_MISS out of range");
    if (ADDR_W < 16 || ADDR_W > 64) $error("ADDR_W out of range");
  end

  // checks look one edge after the cause, where the registered result first shows
  sel_pulse_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && s_r.en && |(sel & ev) |=> event_pulse)
    else $error("selected event produced no pulse");

  no_pulse_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && !(s_r.en && |(sel & ev)) |=> !event_pulse)
    else $error("pulse without a selected event");

  hold_commit_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    load_stall && !(ce && store_committed) |=> load_stall)
    else $error("load released before store commit");

  partial_ovl_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && load_valid && ovl_block && !load_stall |=> load_stall && s_r.status[EV_OVL])
    else $error("blocked load not held or not flagged");

  straddle_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && load_valid && !load_stall && straddle && load_sz != SZ_16 |=> load_stall)
    else $error("straddling load not blocked");

  alias_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && load_valid && !load_stall && alias_4k |=> load_stall)
    else $error("4k aliased load not blocked");

  retire_ev_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && load_valid && (load_uncacheable || line_split) |=> s_r.status[EV_RET])
    else $error("uncacheable or split load not held to retire");

  l1d_full_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && load_valid && load_l1_miss && miss_full |=> s_r.status[EV_L1D])
    else $error("miss-full block not flagged");

  drain_pulse_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && s_r.en && sel[EV_DRN] && drain_cycle |=> event_pulse)
    else $error("drain cycle not counted");

  irq_level_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && |(s_r.status & s_r.mask) && !acc_wr |=> irq)
    else $error("unmasked status without interrupt");

  apb_ready_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup |=> pready ##1 (!pready || !ce))
    else $error("apb answer not one cycle after setup");

  unmapped_err_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && setup && !reg_hit(paddr) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped address not refused");

  miss_cap_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    s_r.misses <= MISS_MAX)
    else $error("miss count above limit");

  order_pulse_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && s_r.en && sel[EV_ORD] && order_stall |=> event_pulse)
    else $error("ordering stall cycle not counted");

  l1d_other_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && load_valid && (line_split || load_io || locked_load_busy) |=> s_r.status[EV_L1D])
    else $error("cache block cause not flagged");

  retire_defer_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && load_valid && load_deferred |=> s_r.status[EV_RET])
    else $error("deferred load not flagged");

  drain_flag_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && drain_cycle |=> s_r.status[EV_DRN])
    else $error("drain cycle not flagged");

  hold_cause_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    !load_stall && !(ce && load_valid && ovl_block) |=> !load_stall)
    else $error("hold without a blocked load");

  w1c_clear_a:
  assert property (@(posedge pclk) disable iff (!presetn)
    ce && acc_wr && paddr == OFS_STATUS && pwdata[EV_ORD] && !order_stall |=> !s_r.status[EV_ORD])
    else $error("status bit not cleared");
endmodule

// ==== testbench/perf_counter_model.sv ====
// counter that sits behind the monitor's event pulse
// assumes the pulse is registered on pclk, one cycle per event
`timescale 1ns/1ps
module perf_counter_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        event_pulse,
  output logic      [31:0] count
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 32'h00000000;
    end else if (event_pulse) begin
      count <= count + 32'h00000001;
    end
  end
endmodule

// ==== testbench/tb_lsb_event_monitor.sv ====
// self-checking bench of the load/store event monitor
// assumes the design package and a 125 MHz pclk; apb master in here
`timescale 1ns/1ps
module tb_lsb_event_monitor;
  import lsb_event_pkg::*;
  localparam int MM = 2;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, r, cnt, load_addr, store_addr;
  logic        event_pulse, load_stall, store_order_stall, irq, load_valid, store_valid;
  logic        load_uncacheable, load_io, load_deferred, load_l1_miss, locked_load_busy;
  logic        store_committed, miss_alloc, miss_done, sb_empty, store_wait;
  logic        st_l1_miss, st_hit_shared, bus_read, snoop_resp, line_observed;
  logic [3:0]  cause;
  logic [2:0]  load_sz, store_sz;
  logic [4:0]  fl;
  int          num_errors, checks_done, cycles, exp_cnt;

  lsb_event_monitor #(.ADDR_W(32), .MAX_MISS(MM)) u_lsb_event_monitor (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .load_valid, .load_addr, .load_sz, .load_uncacheable, .load_io, .load_deferred, .load_l1_miss,
    .locked_load_busy, .store_valid, .store_addr, .store_sz, .store_committed, .miss_alloc, .miss_done,
    .serialize_op(cause[0]), .atomic_exchange_op(cause[1]), .int_ack(cause[2]), .cache_flush(cause[3]),
    .sb_empty, .store_wait, .st_l1_miss, .st_hit_shared, .bus_read, .snoop_resp, .line_observed,
    .event_pulse, .load_stall, .store_order_stall, .irq);
  perf_counter_model u_perf_counter_model (.pclk, .presetn, .event_pulse, .count(cnt));

  assign {load_uncacheable, load_io, load_deferred, load_l1_miss, locked_load_busy} = fl;

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // integer model of the overlap hold
  function automatic logic blk(input logic [31:0] la, sa, input logic [2:0] ls, ss, input logic sv);
    int lb, sb;
    lb = 1 << ls;
    sb = 1 << ss;
    if (ls != SZ_16 && (la % 8) + lb > 8) return 1'b1;
    if (!sv) return 1'b0;
    if (la[11:0] == sa[11:0] && la[31:12] != sa[31:12]) return 1'b1;
    if (la >= sa + sb || sa >= la + lb) return 1'b0;
    if (la < sa || la + lb > sa + sb) return 1'b1;
    if (sa % sb != 0) return la != sa;
    if (lb <= 2) return la != sa;
    return (lb <= 8) && (la % lb != 0);
  endfunction

  // setup, access, then hold until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ld(input logic [15:0] sel, input logic [31:0] la, sa, input logic [2:0] ls, ss,
                    input logic sv, input logic [4:0] f, input logic exp);
    logic b;
    b = blk(la, sa, ls, ss, sv);
    apb(1'b1, OFS_SELECT, {16'h0000, sel});
    @(posedge pclk);
    {load_valid, load_addr, load_sz, store_valid, store_addr, store_sz, fl} <= {1'b1, la, ls, sv, sa, ss, f};
    @(posedge pclk);
    {load_valid, store_valid, fl} <= '0;
    #1 check("event_pulse", event_pulse, exp);
    check("load_stall", load_stall, b);
    exp_cnt += exp;
    if (b) begin
      repeat (3) @(posedge pclk);
      #1 check("load_stall held", load_stall, 1);
      @(posedge pclk) store_committed <= 1'b1;
      @(posedge pclk) store_committed <= 1'b0;
      #1 check("load_stall released", load_stall, 0);
    end
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, load_valid, load_addr, load_sz, store_valid} = '0;
    {store_addr, store_sz, fl, store_committed, miss_alloc, miss_done, cause, store_wait} = '0;
    {st_l1_miss, st_hit_shared, bus_read, snoop_resp, line_observed, cycles, exp_cnt} = '0;
    {num_errors, checks_done} = '0;
    ce = 1'b1;
    sb_empty = 1'b1;
    presetn = 1'b0;
    r = 32'h529EFEDF;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1 check("outputs at reset", {event_pulse, load_stall, store_order_stall, irq}, 0);
    apb(1'b0, OFS_SELECT, 0);
    check("select reset", rd, {16'h0000, RST_UMASK, RST_CODE});
    apb(1'b0, 8'h40, 32'hFFFFFFFF);
    check("unmapped err", err, 1);
    check("unmapped rdata", rd, 0);
    apb(1'b1, OFS_CTRL, 32'h00000001);
    apb(1'b1, OFS_MASK, 32'h00000001);
    ld({UM_OVERLAP, EVC_LOAD_BLOCK}, 32'h1010, 32'h2010, SZ_8, SZ_8, 1, 0, 1);
    ld({UM_OVERLAP, EVC_LOAD_BLOCK}, 32'h0101, 32'h0100, SZ_1, SZ_4, 1, 0, 1);
    ld({UM_OVERLAP, EVC_LOAD_BLOCK}, 32'h0100, 32'h0100, SZ_1, SZ_4, 1, 0, 0);
    ld({UM_OVERLAP, EVC_LOAD_BLOCK}, 32'h0106, 32'h0000, SZ_16, SZ_1, 0, 0, 0);
    ld({UM_UNTIL_RETIRE, EVC_LOAD_BLOCK}, 32'h0200, 0, SZ_4, SZ_4, 0, 5'h10, 1);
    ld({UM_UNTIL_RETIRE, EVC_LOAD_BLOCK}, 32'h023C, 0, SZ_8, SZ_4, 0, 5'h04, 1);
    ld({UM_L1D, EVC_LOAD_BLOCK}, 32'h0300, 0, SZ_4, SZ_4, 0, 5'h01, 1);
    ld({UM_L1D, EVC_LOAD_BLOCK}, 32'h0300, 0, SZ_4, SZ_4, 0, 5'h08, 1);
    ld({UM_L1D, EVC_LOAD_BLOCK}, 32'h033C, 0, SZ_8, SZ_4, 0, 5'h00, 1);
    ld({UM_DRAIN, EVC_STORE_BLOCK}, 32'h0106, 0, SZ_4, SZ_4, 0, 5'h00, 0);
    check("irq", irq, 1);
    apb(1'b1, OFS_STATUS, 32'h0000001F);
    apb(1'b0, OFS_STATUS, 0);
    check("status cleared", rd, 0);
    check("irq cleared", irq, 0);
    repeat (40) begin
      r = nxt(r);
      ld({UM_OVERLAP, EVC_LOAD_BLOCK}, {19'h0, ~r[16], 7'h0, r[12:8]}, {19'h1, 8'h0, r[4:0]},
         (r[15:13] > 3'h4) ? SZ_4 : r[15:13], r[6:5], 1, 0,
         blk({19'h0, ~r[16], 7'h0, r[12:8]}, {19'h1, 8'h0, r[4:0]}, (r[15:13] > 3'h4) ? SZ_4 : r[15:13], r[6:5], 1));
    end
    check("counter", cnt, exp_cnt);
    @(posedge pclk) miss_alloc <= 1'b1;
    repeat (MM + 1) @(posedge pclk);
    miss_alloc <= 1'b0;
    apb(1'b0, OFS_STATE, 0);
    check("miss count", rd[15:8], MM);
    ld({UM_L1D, EVC_LOAD_BLOCK}, 32'h0400, 0, SZ_4, SZ_4, 0, 5'h02, 1);
    @(posedge pclk) miss_done <= 1'b1;
    repeat (MM) @(posedge pclk);
    miss_done <= 1'b0;
    {ce, miss_alloc} <= 2'b01;
    repeat (3) @(posedge pclk);
    {ce, miss_alloc} <= 2'b10;
    apb(1'b0, OFS_STATE, 0);
    check("miss count frozen", rd[15:8], 0);
    ld({UM_L1D, EVC_LOAD_BLOCK}, 32'h0400, 0, SZ_4, SZ_4, 0, 5'h02, 0);
    apb(1'b1, OFS_SELECT, {16'h0000, UM_DRAIN, EVC_STORE_BLOCK});
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      cause <= 4'h1 << i;
      sb_empty <= 1'b0;
      @(posedge pclk) cause <= 4'h0;
      repeat (2) @(posedge pclk);
      repeat (3) begin
        #1 check("drain pulse", event_pulse, 1);
        @(posedge pclk);
      end
      sb_empty <= 1'b1;
      repeat (3) @(posedge pclk);
      #1 check("drain over", event_pulse, 0);
    end
    apb(1'b1, OFS_SELECT, {16'h0000, UM_ORDER, EVC_STORE_BLOCK});
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      {store_wait, st_l1_miss, st_hit_shared, bus_read} <= {1'b1, i == 0, i == 1, i == 0};
      @(posedge pclk) {store_wait, st_l1_miss, st_hit_shared, bus_read} <= '0;
      repeat (3) @(posedge pclk);
      #1 check("order stall", {store_order_stall, event_pulse}, (i < 2) ? 3 : 0);
      if (i == 0) begin
        @(posedge pclk) line_observed <= 1'b1;
        @(posedge pclk) line_observed <= 1'b0;
        repeat (2) @(posedge pclk);
        #1 check("stall waits snoop", store_order_stall, 1);
      end
      @(posedge pclk) {snoop_resp, line_observed} <= {i == 0, i != 0};
      @(posedge pclk) {snoop_resp, line_observed} <= '0;
      repeat (2) @(posedge pclk);
      #1 check("stall ended", {store_order_stall, event_pulse}, 0);
    end
    results();
  end
endmodule
